// File: rtl/cct_defs.svh
// constants of the control command transport: addresses, codes, timing
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

`define CCT_I2C_ADDR    7'h2c
`define CCT_I2C_WR      1'b0
`define CCT_I2C_RD      1'b1

`define CCT_ST_DONE     8'h00
`define CCT_ST_WAIT     8'h01
`define CCT_ST_INVALID  8'h03

`define CCT_HDR_BYTES   8'd3
`define CCT_MAX_PAY     8'd4
`define CCT_GET_LEN_MAX 8'd5

`define CCT_FRAME_MS    15
`define CCT_CLK_KHZ     100000
`define CCT_FRAME_CYC   (`CCT_FRAME_MS * `CCT_CLK_KHZ)

`define CCT_SCL_QTR     16
`define CCT_RETRY_CYC   1000

`define CCT_QGUARD      8
`define CCT_Q_HALF      40'sh0000000080

`endif

// File: rtl/cct_pkg.sv
// types and shared helpers of the control command transport
package cct_pkg;
`include "cct_defs.svh"

  typedef enum logic [1:0] {LNK_IDLE, LNK_ADDR, LNK_WR, LNK_RD} cct_lnk_st_t;
  typedef enum logic [2:0] {HST_IDLE, HST_START, HST_BIT, HST_STOP, HST_GAP} cct_hst_st_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] cmd;
    logic [7:0] len;
  } cct_hdr_t;

  typedef struct packed {
    logic        vld;
    logic [7:0]  res;
    logic [7:0]  cmd;
    logic [7:0]  len;
    logic [31:0] val;
  } cct_pub_t;

  typedef struct packed {
    cct_lnk_st_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  idx;
    logic [7:0]  res;
    logic [7:0]  cmd;
    logic [7:0]  len;
    logic [31:0] wval;
    logic        ack;
    logic [7:0]  tx;
    logic [7:0]  rdidx;
    logic [7:0]  status;
    logic [31:0] rval;
    logic        seen;
    logic        req_tgl;
    logic        take_tgl;
    logic        set_tgl;
    cct_pub_t    s1;
    cct_pub_t    s2;
  } cct_lnk_t;

  typedef struct packed {
    logic [2:0]  req_sy;
    logic [2:0]  take_sy;
    logic [2:0]  set_sy;
    logic        q_vld;
    cct_hdr_t    q;
    logic [31:0] fcnt;
    logic        svc;
    cct_pub_t    pub;
    logic        set_stb;
    cct_hdr_t    set_hdr;
    logic [31:0] set_data;
    logic        get_stb;
    cct_hdr_t    get_hdr;
  } cct_sys_t;

  typedef struct packed {
    cct_hst_st_t st;
    logic [7:0]  qc;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [8:0]  pos;
    logic [7:0]  sh;
    logic        ackb;
    logic        get;
    cct_hdr_t    hdr;
    logic [31:0] wdata;
    logic [7:0]  status;
    logic [31:0] rdata;
    logic        scl;
    logic        sda_oe_n;
    logic        busy;
    logic        done;
    logic        nack;
    logic [15:0] gap;
    logic        s1;
    logic        s2;
  } cct_hst_t;

  // byte k of an n-byte value, most significant byte first
  function automatic logic [7:0] cct_pick(input logic [31:0] val,
                                          input logic [7:0]  nbytes,
                                          input logic [7:0]  k);
    logic [7:0] sel;
    sel = nbytes - 8'd1 - k;
    if (k >= nbytes || sel > 8'd3)
      return 8'h00;
    return val[{sel[1:0], 3'b000} +: 8];
  endfunction : cct_pick

  // signed q value with guard bits, rounded to nearest, not truncated
  function automatic logic [31:0] cct_qround(input logic signed [39:0] x);
    logic signed [39:0] r;
    r = x + `CCT_Q_HALF;
    return r[`CCT_QGUARD +: 32];
  endfunction : cct_qround

  // vendor setup packet: index carries resource, value command, length payload
  function automatic cct_hdr_t cct_setup_hdr(input logic [63:0] setup);
    cct_hdr_t h;
    h.res = setup[39:32];
    h.cmd = setup[23:16];
    h.len = setup[55:48];
    return h;
  endfunction : cct_setup_hdr

endpackage : cct_pkg

// File: rtl/cct_link_if.sv
// two-wire link between host master and device endpoint
`timescale 1ns/1ps
interface cct_link_if;
  logic scl;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic sda;

  // open drain with pull-up: low when either end enables its driver
  assign sda = host_sda_oe_n & dev_sda_oe_n;

  modport host (output scl, output host_sda_oe_n, input sda);
  modport dev  (input scl, input sda, output dev_sda_oe_n);
endinterface : cct_link_if

// File: rtl/cct_dev.sv
// device end: two-wire command endpoint with a per-frame read service queue
//
// Functional notes
// - multi-byte values travel most significant first
// - each command carries 8-bit resource id
// - each command carries 8-bit command id
// - host write length equals parameter byte count
// - host read length is bytes plus one
// - read answer starts with status byte
// - status 0 means value valid
// - status 1 means not yet serviced
// - status 3 flags erroneous read, host abandons
// - host retries pending read until done
// - first queued read serviced within frame
// - device answers at address 0x2c only
// - host read: header, repeated start, read
// - read phase sends status then payload
// - vendor setup fields map to header
// - fractions use signed Qm.n fixed point
// - host rounds to nearest when converting
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_dev
  import cct_pkg::*;
#(
  parameter int FRAME_CYC = `CCT_FRAME_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  cct_link_if.dev          link,
  output logic             set_stb_o,
  output logic [7:0]       set_res_o,
  output logic [7:0]       set_cmd_o,
  output logic [7:0]       set_len_o,
  output logic [31:0]      set_data_o,
  output logic             get_stb_o,
  output logic [7:0]       get_res_o,
  output logic [7:0]       get_cmd_o,
  output logic [7:0]       get_len_o,
  input  wire logic [31:0] get_val_i
);

  ////////////////////////////////////////////////////////////////////////////
  // start detection: sda falling while scl high

  logic start_tgl_ff;

  // the link clock stands still between frames, so an async clear is used here
  always_ff @(negedge link.sda or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_tgl_ff <= 1'b0;
    else if (link.scl)
      start_tgl_ff <= ~start_tgl_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain, clocked by scl

  cct_lnk_t lnk_ff;
  cct_lnk_t nxt_lnk;
  cct_sys_t sys_ff;
  cct_sys_t nxt_sys;
  logic     drv_n_ff;
  logic [7:0] rx_byte;
  logic [8:0] data_cnt;

  always_comb
  begin
    nxt_lnk  = lnk_ff;
    rx_byte  = {lnk_ff.sh[6:0], link.sda};
    data_cnt = {1'b0, lnk_ff.idx} - 9'd2;
    // result words are captured only at frame service, long before they are read
    nxt_lnk.s1 = sys_ff.pub;
    nxt_lnk.s2 = lnk_ff.s1;
    if (start_tgl_ff != lnk_ff.seen)
    begin
      nxt_lnk.seen = start_tgl_ff;
      nxt_lnk.st   = LNK_ADDR;
      nxt_lnk.cnt  = 4'd1;
      nxt_lnk.sh   = {7'h00, link.sda};
      nxt_lnk.ack  = 1'b0;
    end
    else if (lnk_ff.st != LNK_IDLE)
    begin
      if (lnk_ff.cnt == 4'd8)
      begin
        nxt_lnk.cnt = 4'd0;
        nxt_lnk.ack = 1'b0;
        if (lnk_ff.st == LNK_RD && !lnk_ff.ack)
        begin
          if (link.sda)
            nxt_lnk.st = LNK_IDLE;
          else
          begin
            // payload follows the status byte, most significant first
            nxt_lnk.tx = (lnk_ff.status == `CCT_ST_DONE) ?
                         cct_pick(lnk_ff.rval, lnk_ff.len - 8'd1, lnk_ff.rdidx) : 8'h00;
            nxt_lnk.rdidx = lnk_ff.rdidx + 8'd1;
          end
        end
      end
      else
      begin
        nxt_lnk.cnt = lnk_ff.cnt + 4'd1;
        nxt_lnk.sh  = rx_byte;
        if (lnk_ff.cnt == 4'd7)
        begin
          case (lnk_ff.st)
            LNK_ADDR:
            begin
              if (rx_byte[7:1] == `CCT_I2C_ADDR)
              begin
                nxt_lnk.ack = 1'b1;
                if (rx_byte[0] == `CCT_I2C_RD)
                begin
                  nxt_lnk.st    = LNK_RD;
                  nxt_lnk.rdidx = 8'd0;
                  if (lnk_ff.idx < `CCT_HDR_BYTES || lnk_ff.len == 8'h00 ||
                      lnk_ff.len > `CCT_GET_LEN_MAX)
                    nxt_lnk.status = `CCT_ST_INVALID;
                  else if (lnk_ff.s2.vld && lnk_ff.s2.res == lnk_ff.res &&
                           lnk_ff.s2.cmd == lnk_ff.cmd && lnk_ff.s2.len == lnk_ff.len)
                  begin
                    nxt_lnk.status   = `CCT_ST_DONE;
                    nxt_lnk.rval     = lnk_ff.s2.val;
                    nxt_lnk.take_tgl = ~lnk_ff.take_tgl;
                  end
                  else
                  begin
                    nxt_lnk.status  = `CCT_ST_WAIT;
                    nxt_lnk.req_tgl = ~lnk_ff.req_tgl;
                  end
                  nxt_lnk.tx = nxt_lnk.status; // status leads the answer
                end
                else
                begin
                  nxt_lnk.st   = LNK_WR;
                  nxt_lnk.idx  = 8'd0;
                  nxt_lnk.wval = 32'h0000_0000;
                end
              end
              else
                nxt_lnk.st = LNK_IDLE;
            end
            LNK_WR:
            begin
              nxt_lnk.ack = 1'b1;
              case (lnk_ff.idx)
                8'd0:    nxt_lnk.res = rx_byte;
                8'd1:    nxt_lnk.cmd = rx_byte;
                8'd2:    nxt_lnk.len = rx_byte;
                default:
                begin
                  // big-endian accumulation of the written value
                  nxt_lnk.wval = {lnk_ff.wval[23:0], rx_byte};
                  if (data_cnt == {1'b0, lnk_ff.len})
                    nxt_lnk.set_tgl = ~lnk_ff.set_tgl;
                end
              endcase
              if (lnk_ff.idx != 8'hff)
                nxt_lnk.idx = lnk_ff.idx + 8'd1;
            end
            default:
            begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge link.scl or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lnk_ff <= '0;
    else
      lnk_ff <= nxt_lnk;
  end

  // data changes on the falling edge, stable through the high phase
  always_ff @(negedge link.scl or negedge rst_n_i)
  begin
    if (!rst_n_i)
      drv_n_ff <= 1'b1;
    else if (lnk_ff.cnt == 4'd8 && lnk_ff.ack)
      drv_n_ff <= 1'b0;
    else if (lnk_ff.st == LNK_RD && lnk_ff.cnt < 4'd8)
      drv_n_ff <= lnk_ff.tx[3'd7 - lnk_ff.cnt[2:0]];
    else
      drv_n_ff <= 1'b1;
  end

  assign link.dev_sda_oe_n = drv_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: toggle sync, read queue, frame service

  always_comb
  begin
    nxt_sys         = sys_ff;
    nxt_sys.req_sy  = {sys_ff.req_sy[1:0], lnk_ff.req_tgl};
    nxt_sys.take_sy = {sys_ff.take_sy[1:0], lnk_ff.take_tgl};
    nxt_sys.set_sy  = {sys_ff.set_sy[1:0], lnk_ff.set_tgl};
    nxt_sys.set_stb = 1'b0;
    nxt_sys.get_stb = 1'b0;
    if (sys_ff.fcnt == 32'(FRAME_CYC - 1))
      nxt_sys.fcnt = 32'h0000_0000;
    else
      nxt_sys.fcnt = sys_ff.fcnt + 32'h0000_0001;
    // value handed out: free the result slot
    if (sys_ff.take_sy[2] ^ sys_ff.take_sy[1])
      nxt_sys.pub.vld = 1'b0;
    // only the first pending read is kept; retries of it are absorbed
    if ((sys_ff.req_sy[2] ^ sys_ff.req_sy[1]) && !sys_ff.q_vld)
    begin
      nxt_sys.q_vld = 1'b1;
      nxt_sys.q     = '{res: lnk_ff.res, cmd: lnk_ff.cmd, len: lnk_ff.len};
    end
    if (sys_ff.fcnt == 32'(FRAME_CYC - 1) && sys_ff.q_vld && !sys_ff.svc)
    begin
      nxt_sys.get_stb = 1'b1;
      nxt_sys.get_hdr = sys_ff.q;
      nxt_sys.svc     = 1'b1;
    end
    // capture wins over a clear arriving in the same cycle
    if (sys_ff.svc)
    begin
      nxt_sys.pub   = '{vld: 1'b1, res: sys_ff.get_hdr.res, cmd: sys_ff.get_hdr.cmd,
                        len: sys_ff.get_hdr.len, val: get_val_i};
      nxt_sys.q_vld = 1'b0;
      nxt_sys.svc   = 1'b0;
    end
    if (sys_ff.set_sy[2] ^ sys_ff.set_sy[1])
    begin
      nxt_sys.set_stb  = 1'b1;
      nxt_sys.set_hdr  = '{res: lnk_ff.res, cmd: lnk_ff.cmd, len: lnk_ff.len};
      nxt_sys.set_data = lnk_ff.wval;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sys_ff <= '0;
    else
      sys_ff <= nxt_sys;
  end

  assign set_stb_o  = sys_ff.set_stb;
  assign set_res_o  = sys_ff.set_hdr.res;
  assign set_cmd_o  = sys_ff.set_hdr.cmd;
  assign set_len_o  = sys_ff.set_hdr.len;
  assign set_data_o = sys_ff.set_data;
  assign get_stb_o  = sys_ff.get_stb;
  assign get_res_o  = sys_ff.get_hdr.res;
  assign get_cmd_o  = sys_ff.get_hdr.cmd;
  assign get_len_o  = sys_ff.get_hdr.len;

endmodule : cct_dev

// File: rtl/cct_host.sv
// host end: two-wire master issuing set and get commands with automatic retry
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_host
  import cct_pkg::*;
#(
  parameter int QTR_CYC   = `CCT_SCL_QTR,
  parameter int RETRY_CYC = `CCT_RETRY_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  cct_link_if.host         link,
  input  wire logic        req_i,
  input  wire logic        get_i,
  input  wire logic [7:0]  res_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [7:0]  len_i,
  input  wire logic [39:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic [7:0]       status_o,
  output logic [31:0]      rdata_o
);

  cct_hst_t hst_ff;
  cct_hst_t nxt_hst;
  logic     tick;
  logic     rd;
  logic     last;

  // byte sent at a position of the sequence
  function automatic logic [7:0] hst_byte(input cct_hst_t h, input logic [8:0] p);
    case (p)
      9'd0:    return {`CCT_I2C_ADDR, `CCT_I2C_WR};
      9'd1:    return h.hdr.res;
      9'd2:    return h.hdr.cmd;
      9'd3:    return h.hdr.len;
      default: return h.get ? {`CCT_I2C_ADDR, `CCT_I2C_RD} :
                      cct_pick(h.wdata, h.hdr.len, p[7:0] - 8'd4);
    endcase
  endfunction : hst_byte

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    nxt_hst      = hst_ff;
    nxt_hst.done = 1'b0;
    nxt_hst.s1   = link.sda;
    nxt_hst.s2   = hst_ff.s1;
    tick         = (hst_ff.qc == 8'(QTR_CYC - 1));
    nxt_hst.qc   = tick ? 8'h00 : hst_ff.qc + 8'h01;
    rd           = hst_ff.get && hst_ff.pos >= 9'd5;
    last         = hst_ff.get ? (hst_ff.pos == 9'd4 + {1'b0, hst_ff.hdr.len}) :
                                (hst_ff.pos == 9'd3 + {1'b0, hst_ff.hdr.len});
    if (tick && (hst_ff.st == HST_START || hst_ff.st == HST_BIT || hst_ff.st == HST_STOP))
      nxt_hst.ph = hst_ff.ph + 2'd1;
    case (hst_ff.st)
      HST_IDLE:
      begin
        if (req_i)
        begin
          nxt_hst.st    = HST_START;
          nxt_hst.busy  = 1'b1;
          nxt_hst.nack  = 1'b0;
          nxt_hst.get   = get_i;
          // length: value bytes for set, value bytes plus status for get
          nxt_hst.hdr   = '{res: res_i, cmd: cmd_i, len: len_i};
          nxt_hst.wdata = cct_qround(wdata_i);
          nxt_hst.rdata = 32'h0000_0000;
          nxt_hst.pos   = 9'd0;
          nxt_hst.ph    = 2'd0;
          nxt_hst.qc    = 8'h00;
        end
      end
      HST_START:
      begin
        if (tick)
        begin
          case (hst_ff.ph)
            2'd0:    nxt_hst.sda_oe_n = 1'b1;
            2'd1:    nxt_hst.scl = 1'b1;
            2'd2:    nxt_hst.sda_oe_n = 1'b0;
            default:
            begin
              nxt_hst.scl  = 1'b0;
              nxt_hst.st   = HST_BIT;
              nxt_hst.bitn = 4'd0;
              nxt_hst.sh   = hst_byte(hst_ff, hst_ff.pos);
            end
          endcase
        end
      end
      HST_BIT:
      begin
        if (tick)
        begin
          case (hst_ff.ph)
            2'd0:
              if (hst_ff.bitn == 4'd8)
                nxt_hst.sda_oe_n = rd ? last : 1'b1;
              else
                nxt_hst.sda_oe_n = rd ? 1'b1 : hst_ff.sh[7];
            2'd1:    nxt_hst.scl = 1'b1;
            2'd2:
              if (hst_ff.bitn == 4'd8)
                nxt_hst.ackb = hst_ff.s2;
              else if (rd)
                nxt_hst.sh = {hst_ff.sh[6:0], hst_ff.s2};
            default:
            begin
              nxt_hst.scl = 1'b0;
              if (hst_ff.bitn != 4'd8)
              begin
                nxt_hst.bitn = hst_ff.bitn + 4'd1;
                if (!rd)
                  nxt_hst.sh = {hst_ff.sh[6:0], 1'b0};
              end
              else if (!rd && hst_ff.ackb)
              begin
                nxt_hst.nack = 1'b1;
                nxt_hst.st   = HST_STOP;
              end
              else
              begin
                if (rd && hst_ff.pos == 9'd5)
                  nxt_hst.status = hst_ff.sh;
                else if (rd)
                  nxt_hst.rdata = {hst_ff.rdata[23:0], hst_ff.sh};
                if (last)
                  nxt_hst.st = HST_STOP;
                else if (hst_ff.get && hst_ff.pos == 9'd3)
                begin
                  nxt_hst.st  = HST_START; // repeated start before reading
                  nxt_hst.pos = 9'd4;
                end
                else
                begin
                  nxt_hst.pos  = hst_ff.pos + 9'd1;
                  nxt_hst.sh   = hst_byte(hst_ff, hst_ff.pos + 9'd1);
                  nxt_hst.bitn = 4'd0;
                end
              end
            end
          endcase
        end
      end
      HST_STOP:
      begin
        if (tick)
        begin
          case (hst_ff.ph)
            2'd0:    nxt_hst.sda_oe_n = 1'b0;
            2'd1:    nxt_hst.scl = 1'b1;
            2'd2:    nxt_hst.sda_oe_n = 1'b1;
            default:
            begin
              if (!hst_ff.nack && hst_ff.get && hst_ff.status == `CCT_ST_WAIT)
              begin
                nxt_hst.st  = HST_GAP;
                nxt_hst.gap = 16'h0000;
              end
              else
              begin
                // an invalid status ends the request as it stands
                nxt_hst.st   = HST_IDLE;
                nxt_hst.busy = 1'b0;
                nxt_hst.done = 1'b1;
                if (!hst_ff.get && !hst_ff.nack)
                  nxt_hst.status = `CCT_ST_DONE;
              end
            end
          endcase
        end
      end
      HST_GAP:
      begin
        nxt_hst.gap = hst_ff.gap + 16'h0001;
        if (hst_ff.gap == 16'(RETRY_CYC - 1))
        begin
          nxt_hst.st    = HST_START; // same read again
          nxt_hst.pos   = 9'd0;
          nxt_hst.ph    = 2'd0;
          nxt_hst.qc    = 8'h00;
          nxt_hst.rdata = 32'h0000_0000;
        end
      end
      default:
        nxt_hst.st = HST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hst_ff          <= '0;
      hst_ff.scl      <= 1'b1;
      hst_ff.sda_oe_n <= 1'b1;
    end
    else
      hst_ff <= nxt_hst;
  end

  assign link.scl           = hst_ff.scl;
  assign link.host_sda_oe_n = hst_ff.sda_oe_n;
  assign busy_o             = hst_ff.busy;
  assign done_o             = hst_ff.done;
  assign nack_o             = hst_ff.nack;
  assign status_o           = hst_ff.status;
  assign rdata_o            = hst_ff.rdata;

endmodule : cct_host

// File: verif/cct_link_checker.sv
// link protocol checker for the two-wire command transport
`timescale 1ns/1ps
module cct_link_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // link is sampled on the system clock: scl comes from a host flop
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  //////////////////////////////////////////////////////////////////////////////
  a_scl_high_span: assert property ($rose(scl) |=> scl[*8])
    else $error("scl high phase too short");
  a_scl_low_span: assert property ($fell(scl) |=> (!scl)[*8])
    else $error("scl low phase too short");
  a_scl_low_bound: assert property ($fell(scl) |-> ##[30:34] scl)
    else $error("scl low phase too long");
  a_dev_edge_only: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while scl high");
  a_dev_drive_hold: assert property ($fell(dev_sda_oe_n) |=> (!dev_sda_oe_n)[*8])
    else $error("device bit did not stand");
  a_dev_release_hold: assert property ($rose(dev_sda_oe_n) |=> dev_sda_oe_n[*8])
    else $error("device released bit did not stand");
  a_start_then_low: assert property ($fell(sda) && scl |-> ##[15:17] !scl)
    else $error("start not followed by scl low");
  a_stop_bus_idle: assert property ($rose(sda) && scl |=> (scl && sda)[*8])
    else $error("bus not idle after stop");

  //////////////////////////////////////////////////////////////////////////////
  c_start: cover property ($fell(sda) && scl);
  c_dev_drive: cover property ($fell(dev_sda_oe_n));
  c_stop: cover property ($rose(sda) && scl);
endmodule : cct_link_checker

// File: verif/control_command_transport_tb_top.sv
// testbench: host and device ends joined over the two-wire link
`timescale 1ns/1ps
module control_command_transport_tb_top;
  import cct_pkg::*;
  // short frame keeps the retry path inside a few thousand cycles
  localparam int FRAME = 2000;
  localparam int LIMIT = 80000;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b1;
  logic        req_i = 1'b0;
  logic        get_i = 1'b0;
  logic [7:0]  res_i = 8'h00;
  logic [7:0]  cmd_i = 8'h00;
  logic [7:0]  len_i = 8'h00;
  logic [39:0] wdata_i = 40'h0;
  logic [31:0] get_val_i = 32'h0;
  logic        busy_o, done_o, nack_o, set_stb_o, get_stb_o;
  logic [7:0]  status_o, set_res_o, set_cmd_o, set_len_o, get_res_o, get_cmd_o, get_len_o;
  logic [31:0] rdata_o, set_data_o;
  int          failures = 0, compares = 0, cyc = 0, n_set = 0, n_get = 0;

  always #5 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////////////
  cct_link_if lnk ();
  cct_host #(.QTR_CYC(16), .RETRY_CYC(1000)) u_cct_host (
    .clk_i, .rst_n_i, .link(lnk), .req_i, .get_i, .res_i, .cmd_i, .len_i, .wdata_i,
    .busy_o, .done_o, .nack_o, .status_o, .rdata_o);
  cct_dev #(.FRAME_CYC(FRAME)) u_cct_dev (
    .clk_i, .rst_n_i, .link(lnk), .set_stb_o, .set_res_o, .set_cmd_o, .set_len_o,
    .set_data_o, .get_stb_o, .get_res_o, .get_cmd_o, .get_len_o, .get_val_i);
  cct_link_checker u_cct_link_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl(lnk.scl), .host_sda_oe_n(lnk.host_sda_oe_n),
    .dev_sda_oe_n(lnk.dev_sda_oe_n), .sda(lnk.sda));

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    cyc++;
    if (set_stb_o === 1'b1)
      n_set++;
    if (get_stb_o === 1'b1)
      n_get++;
    if (cyc == LIMIT)
    begin
      failures++;
      end_sim();
    end
  end

  // value is right only in the strobe cycle, so a late sample shows
  always @(negedge clk_i)
    get_val_i <= (get_stb_o === 1'b1) ? {get_res_o, get_cmd_o, 16'hc3a5}
                                       : ~{get_res_o, get_cmd_o, 16'hc3a5};

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic issue(input logic g, input logic [7:0] r, input logic [7:0] c,
                       input logic [7:0] l, input logic [39:0] w, output int t);
    int t0;
    @(negedge clk_i);
    get_i = g;
    res_i = r;
    cmd_i = c;
    len_i = l;
    wdata_i = w;
    req_i = 1'b1;
    t0 = cyc;
    @(negedge clk_i);
    req_i = 1'b0;
    @(negedge clk_i);
    chk("busy", 32'h1, 32'(busy_o));
    while (done_o !== 1'b1)
      @(negedge clk_i);
    t = cyc - t0;
    chk("nack", 32'h0, 32'(nack_o));
    repeat (8) @(negedge clk_i);
  endtask : issue

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_set_word();
    int t;
    issue(1'b0, 8'h21, 8'h07, 8'h04, 40'h12345677_80, t);
    chk("set_res", 32'h21, 32'(set_res_o));
    chk("set_cmd", 32'h07, 32'(set_cmd_o));
    chk("set_len", 32'h4, 32'(set_len_o));
    chk("set_data", 32'h12345678, set_data_o);
    chk("set_count", 32'h1, 32'(n_set));
    $display("test set_word done");
  endtask : t_set_word

  task automatic t_set_half();
    int t;
    issue(1'b0, 8'h4e, 8'h10, 8'h02, 40'h0000abcd7f, t);
    chk("set_len", 32'h2, 32'(set_len_o));
    chk("set_data", 32'habcd, 32'(set_data_o[15:0]));
    chk("set_count", 32'h2, 32'(n_set));
    $display("test set_half done");
  endtask : t_set_half

  task automatic t_get_word();
    int t;
    issue(1'b1, 8'h33, 8'h81, 8'h05, 40'h0, t);
    chk("status", 32'h0, 32'(status_o));
    chk("rdata", 32'h3381c3a5, rdata_o);
    chk("get_hdr", 32'h338105, {8'h0, get_res_o, get_cmd_o, get_len_o});
    chk("setup_hdr", 32'h338105, 32'(cct_setup_hdr(64'h0005_0033_0081_00c1)));
    chk("get_count", 32'h1, 32'(n_get));
    chk("retried", 32'h1, 32'(t > 7000 && t < 15000));
    $display("test get_word done");
  endtask : t_get_word

  task automatic t_get_byte();
    int t;
    issue(1'b1, 8'h05, 8'h02, 8'h02, 40'h0, t);
    chk("status", 32'h0, 32'(status_o));
    chk("rdata", 32'ha5, 32'(rdata_o[7:0]));
    chk("get_len", 32'h2, 32'(get_len_o));
    chk("get_count", 32'h2, 32'(n_get));
    $display("test get_byte done");
  endtask : t_get_byte

  task automatic t_get_bad();
    int t;
    issue(1'b1, 8'h33, 8'h81, 8'h06, 40'h0, t);
    chk("status", 32'h3, 32'(status_o));
    chk("rdata", 32'h0, rdata_o);
    chk("get_count", 32'h2, 32'(n_get));
    chk("no_retry", 32'h1, 32'(t < 8000));
    $display("test get_bad done");
  endtask : t_get_bad

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // link-side flops clear only on a reset edge, so reset must fall once
    #1;
    rst_n_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_set_word();
    t_set_half();
    t_get_word();
    t_get_byte();
    t_get_bad();
    end_sim();
  end
endmodule : control_command_transport_tb_top
